// ---- shared/ddr_ctrl_pkg.sv ----
// What this block does
// - Two independent AXI slave ports, 128-bit data, each on its own clock
// - PHY side runs on a clock at half the lane data rate
// - Up to 1066 Mb/s per data lane for every memory type
// - Sixteen-bit memory interface for DDR3, DDR3L, LPDDR3 and LPDDR2
// - One request channel per port; direction bit 0 read, 1 write
// - 8-bit request tag, read or write tag by direction bit
// - Beat addresses computed from 2-bit burst kind and 3-bit beat size
// - Master holds valid and fields until ready; ready only when acceptable
// - 128-bit write beats, 16 strobes, only strobed byte lanes written
// - Write beat moves only when write valid and write ready both high
// - After write burst, response returns the write tag
// - Write response valid held until master response ready
// - Read data in 128-bit beats tagged with the read tag
// - Final read beat flagged last; 2-bit status with every beat
// - Read beat moves only when read valid and read ready both high
// - No direct PHY path; every access goes through the controller
// - Calibration serial bus reads and writes internal configuration registers
// - Active-low reset; configure and initialise again before any access
`default_nettype none
package ddr_ctrl_pkg;
    // ==========================================================
    // Data path
    localparam int DATA_W = 128;
    localparam int STRB_W = 16;
    localparam int ADDR_W = 32;
    localparam int ID_W = 8;
    localparam int LEN_W = 8;
    localparam int DQ_W = 16;
    localparam int LANE_MBPS = 1066;
    localparam int PHY_CLK_MHZ = LANE_MBPS / 2;
    localparam int BEATS_PER_WORD = DATA_W / DQ_W;
    // ==========================================================
    // Burst kinds and response codes
    localparam logic [1:0] BURST_FIXED = 2'h0;
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic DIR_READ = 1'h0;
    // ==========================================================
    // Storage behind the controller
    localparam int MEM_AW = 6;
    localparam int MEM_WORDS = 64;
    localparam int BEAT_LSB = 4;
    // ==========================================================
    // Timing of the startup sequence
    localparam int CLK_MHZ = 200;
    localparam int INIT_TIME_NS = 100;
    localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
    // ==========================================================
    // Calibration bus
    localparam logic [4:0] CAL_FRAME_BITS = 5'h10;
    localparam logic [4:0] CAL_HDR_BITS = 5'h08;
    localparam int CAL_REGS = 4;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CFG_ARB_BIT = 0;
endpackage
`default_nettype wire

// ---- design/ddr_ctrl.sv ----
`default_nettype none
// ==========================================================
// Per-port front end on its own AXI clock
module ddr_axi_port
    import ddr_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic i_aclk,
    input wire logic i_nrst,
    // Init status from core clock
    input wire logic i_init_done,
    // Shared request channel
    input wire logic i_valid,
    output logic o_ready,
    input wire logic i_dir,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [ID_W-1:0] i_tag,
    input wire logic [LEN_W-1:0] i_beats,
    input wire logic [2:0] i_size,
    input wire logic [1:0] i_kind,
    // Write data channel
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [STRB_W-1:0] i_wstrb,
    // Write response channel
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [ID_W-1:0] o_bid,
    output logic [1:0] o_bresp,
    // Read data channel
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [DATA_W-1:0] o_rdata,
    output logic [ID_W-1:0] o_rid,
    output logic o_rlast,
    output logic [1:0] o_rresp,
    // Crossing to core clock
    output logic o_req_tgl,
    output logic o_op_wr,
    output logic [ADDR_W-1:0] o_op_addr,
    output logic [DATA_W-1:0] o_op_data,
    output logic [STRB_W-1:0] o_op_strb,
    input wire logic i_ack_tgl,
    input wire logic [DATA_W-1:0] i_ack_data
);
    typedef enum logic [2:0] {P_IDLE, P_WDAT, P_WOP, P_BRESP, P_ROP, P_RDAT} pstate_t;

    pstate_t st_r;
    logic init_s1, init_s2, ack_s1, ack_s2, ack_seen_r;
    logic [LEN_W-1:0] len_r, cnt_r;
    logic [2:0] size_r;
    logic [1:0] kind_r;
    logic ack_evt;

    // Next beat address from burst kind and size
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
        input logic [2:0] sz, input logic [1:0] bk, input logic [LEN_W-1:0] ln);
        logic [ADDR_W-1:0] inc;
        logic [ADDR_W-1:0] msk;
        inc = 32'h0000_0001 << sz;
        msk = ({24'h00_0000, ln} + 32'h0000_0001) * inc - 32'h0000_0001;
        case (bk)
            BURST_FIXED: next_addr = a;
            BURST_WRAP: next_addr = (a & ~msk) | ((a + inc) & msk);
            default: next_addr = a + inc;
        endcase
    endfunction

    // Two-flop synchronisers for init level and ack toggle
    always_ff @(posedge i_aclk or negedge i_nrst) begin
        if (!i_nrst) begin
            init_s1 <= 1'b0;
            init_s2 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            init_s1 <= i_init_done;
            init_s2 <= init_s1;
            ack_s1 <= i_ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    assign ack_evt = ack_s2 ^ ack_seen_r;

    // Channel sequencing, one burst at a time
    always_ff @(posedge i_aclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= P_IDLE;
            o_ready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_rvalid <= 1'b0;
            o_rlast <= 1'b0;
            o_bid <= '0;
            o_rid <= '0;
            o_rdata <= '0;
            o_bresp <= RESP_OKAY;
            o_rresp <= RESP_OKAY;
            o_req_tgl <= 1'b0;
            o_op_wr <= 1'b0;
            o_op_addr <= '0;
            o_op_data <= '0;
            o_op_strb <= '0;
            ack_seen_r <= 1'b0;
            len_r <= '0;
            cnt_r <= '0;
            size_r <= '0;
            kind_r <= '0;
        end else begin
            case (st_r)
                P_IDLE: begin
                    o_ready <= init_s2;
                    if (i_valid && o_ready) begin
                        o_ready <= 1'b0;
                        o_op_addr <= i_addr;
                        o_bid <= i_tag;
                        o_rid <= i_tag;
                        len_r <= i_beats;
                        size_r <= i_size;
                        kind_r <= i_kind;
                        cnt_r <= '0;
                        o_op_wr <= i_dir;
                        if (i_dir != DIR_READ) begin
                            o_wready <= 1'b1;
                            st_r <= P_WDAT;
                        end else begin
                            o_req_tgl <= ~o_req_tgl;
                            st_r <= P_ROP;
                        end
                    end
                end
                P_WDAT: begin
                    if (i_wvalid && o_wready) begin
                        o_wready <= 1'b0;
                        o_op_data <= i_wdata;
                        o_op_strb <= i_wstrb;
                        o_req_tgl <= ~o_req_tgl;
                        st_r <= P_WOP;
                    end
                end
                P_WOP: begin
                    if (ack_evt) begin
                        ack_seen_r <= ack_s2;
                        if (cnt_r == len_r) begin
                            o_bvalid <= 1'b1;
                            o_bresp <= RESP_OKAY;
                            st_r <= P_BRESP;
                        end else begin
                            o_op_addr <= next_addr(o_op_addr, size_r, kind_r, len_r);
                            cnt_r <= cnt_r + 8'h01;
                            o_wready <= 1'b1;
                            st_r <= P_WDAT;
                        end
                    end
                end
                P_BRESP: begin
                    if (i_bready) begin
                        o_bvalid <= 1'b0;
                        st_r <= P_IDLE;
                    end
                end
                P_ROP: begin
                    if (ack_evt) begin
                        ack_seen_r <= ack_s2;
                        o_rdata <= i_ack_data;
                        o_rresp <= RESP_OKAY;
                        o_rvalid <= 1'b1;
                        o_rlast <= (cnt_r == len_r);
                        st_r <= P_RDAT;
                    end
                end
                P_RDAT: begin
                    if (i_rready) begin
                        o_rvalid <= 1'b0;
                        o_rlast <= 1'b0;
                        if (o_rlast) begin
                            st_r <= P_IDLE;
                        end else begin
                            o_op_addr <= next_addr(o_op_addr, size_r, kind_r, len_r);
                            cnt_r <= cnt_r + 8'h01;
                            o_req_tgl <= ~o_req_tgl;
                            st_r <= P_ROP;
                        end
                    end
                end
                default: st_r <= P_IDLE;
            endcase
        end
    end

    // Checks on the port protocol
    default clocking @(posedge i_aclk); endclocking
    default disable iff (!i_nrst);
    a_req_accept_drop: assert property ((i_valid && o_ready) |=> !o_ready)
        else $error("request ready stayed high after accept");
    a_ready_needs_init: assert property (o_ready |-> $past(init_s2))
        else $error("request ready before init done");
    a_wbeat_one: assert property ((i_wvalid && o_wready) |=> !o_wready ##1 !o_wready)
        else $error("write ready not dropped after a beat");
    a_bresp_hold: assert property ((o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bid))
        else $error("write response dropped without ready");
    a_bresp_okay: assert property (o_bvalid |-> o_bresp == RESP_OKAY && cnt_r == len_r)
        else $error("write response early or not okay");
    a_rbeat_hold: assert property ((o_rvalid && !i_rready) |=> o_rvalid && $stable(o_rdata))
        else $error("read beat changed before ready");
    a_rlast_count: assert property (o_rvalid |-> (o_rlast == (cnt_r == len_r)))
        else $error("read last does not match beat count");
    a_rresp_okay: assert property (o_rvalid |-> o_rresp == RESP_OKAY)
        else $error("read status not okay");
    a_incr_step: assert property ((st_r == P_RDAT && i_rready && !o_rlast
        && kind_r == BURST_INCR) |=> o_op_addr == $past(o_op_addr) + (32'h0000_0001 << size_r))
        else $error("incrementing burst address step wrong");
endmodule

// ==========================================================
// Controller core: startup, arbitration, storage, calibration
module ddr_ctrl
    import ddr_ctrl_pkg::*;
(
    // Core clock, reset, enable
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Port clocks
    input wire logic [1:0] i_aclk,
    // Startup sequencer
    input wire logic i_config_sequencer_go,
    input wire logic i_config_sequencer_clear,
    output logic o_init_done,
    // Calibration bus
    input wire logic i_cal_scl,
    input wire logic i_cal_sda,
    output logic o_cal_sda_oen,
    // Shared request channels
    input wire logic [1:0] i_shared_request_valid,
    output logic [1:0] o_shared_request_ready,
    input wire logic [1:0] i_request_direction_bit,
    input wire logic [1:0][ADDR_W-1:0] i_shared_request_address,
    input wire logic [1:0][ID_W-1:0] i_shared_request_tag,
    input wire logic [1:0][LEN_W-1:0] i_shared_burst_beats,
    input wire logic [1:0][2:0] i_shared_beat_size,
    input wire logic [1:0][1:0] i_shared_burst_kind,
    input wire logic [1:0][1:0] i_shared_atomic_kind,
    // Write data channels
    input wire logic [1:0] i_wvalid,
    output logic [1:0] o_wready,
    input wire logic [1:0][DATA_W-1:0] i_wdata,
    input wire logic [1:0][STRB_W-1:0] i_wstrb,
    input wire logic [1:0][ID_W-1:0] i_wid,
    input wire logic [1:0] i_wlast,
    // Write response channels
    output logic [1:0] o_bvalid,
    input wire logic [1:0] i_bready,
    output logic [1:0][ID_W-1:0] o_bid,
    output logic [1:0][1:0] o_bresp,
    // Read data channels
    output logic [1:0] o_rvalid,
    input wire logic [1:0] i_rready,
    output logic [1:0][DATA_W-1:0] o_rdata,
    output logic [1:0][ID_W-1:0] o_rid,
    output logic [1:0] o_rlast,
    output logic [1:0][1:0] o_rresp
);
    typedef enum logic [1:0] {S_WAIT, S_INIT, S_RUN} istate_t;

    istate_t ist_r;
    logic [7:0] icnt_r;
    logic [1:0] req_tgl, op_wr, req_s1, req_s2, seen_r, ack_r;
    logic [ADDR_W-1:0] op_addr [2];
    logic [DATA_W-1:0] op_data [2];
    logic [STRB_W-1:0] op_strb [2];
    logic [DATA_W-1:0] ack_data_r [2];
    logic [DATA_W-1:0] mem [MEM_WORDS];
    logic [1:0] pend;
    logic pick, serve, last_r;
    logic [MEM_AW-1:0] idx;
    logic [7:0] cfg_r [CAL_REGS];
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic [4:0] cal_cnt_r;
    logic [14:0] cal_sh_r;
    logic [7:0] cal_tx_r;
    logic cal_rd_r;
    logic cal_start, cal_rise, cal_fall;

    // Port front ends, one per AXI clock
    for (genvar p = 0; p < 2; p++) begin : g_port
        ddr_axi_port u_port (
            .i_aclk(i_aclk[p]),
            .i_nrst(i_nrst),
            .i_init_done(o_init_done),
            .i_valid(i_shared_request_valid[p]),
            .o_ready(o_shared_request_ready[p]),
            .i_dir(i_request_direction_bit[p]),
            .i_addr(i_shared_request_address[p]),
            .i_tag(i_shared_request_tag[p]),
            .i_beats(i_shared_burst_beats[p]),
            .i_size(i_shared_beat_size[p]),
            .i_kind(i_shared_burst_kind[p]),
            .i_wvalid(i_wvalid[p]),
            .o_wready(o_wready[p]),
            .i_wdata(i_wdata[p]),
            .i_wstrb(i_wstrb[p]),
            .o_bvalid(o_bvalid[p]),
            .i_bready(i_bready[p]),
            .o_bid(o_bid[p]),
            .o_bresp(o_bresp[p]),
            .o_rvalid(o_rvalid[p]),
            .i_rready(i_rready[p]),
            .o_rdata(o_rdata[p]),
            .o_rid(o_rid[p]),
            .o_rlast(o_rlast[p]),
            .o_rresp(o_rresp[p]),
            .o_req_tgl(req_tgl[p]),
            .o_op_wr(op_wr[p]),
            .o_op_addr(op_addr[p]),
            .o_op_data(op_data[p]),
            .o_op_strb(op_strb[p]),
            .i_ack_tgl(ack_r[p]),
            .i_ack_data(ack_data_r[p])
        );
    end

    // Startup sequencer: wait for go, count init time, then run
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ist_r <= S_WAIT;
            icnt_r <= '0;
            o_init_done <= 1'b0;
        end else if (i_ce) begin
            if (i_config_sequencer_clear) begin
                ist_r <= S_WAIT;
                o_init_done <= 1'b0;
            end else begin
                case (ist_r)
                    S_WAIT: if (i_config_sequencer_go) begin
                        ist_r <= S_INIT;
                        icnt_r <= '0;
                    end
                    S_INIT: begin
                        icnt_r <= icnt_r + 8'h01;
                        if (icnt_r == 8'(INIT_CYCLES - 1)) begin
                            ist_r <= S_RUN;
                            o_init_done <= 1'b1;
                        end
                    end
                    S_RUN: o_init_done <= 1'b1;
                    default: ist_r <= S_WAIT;
                endcase
            end
        end
    end

    // Request toggle synchronisers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            req_s1 <= '0;
            req_s2 <= '0;
        end else if (i_ce) begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
        end
    end

    // Arbitration: round robin, or port 1 first when configured
    assign pend = req_s2 ^ seen_r;
    assign pick = pend[1] && (!pend[0] || cfg_r[0][CFG_ARB_BIT] || !last_r);
    assign serve = o_init_done && (pend != 2'h0);
    assign idx = op_addr[pick][BEAT_LSB +: MEM_AW];

    // Serve one operation per cycle and answer with ack toggle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            seen_r <= '0;
            ack_r <= '0;
            last_r <= 1'b0;
            for (int k = 0; k < 2; k++) begin
                ack_data_r[k] <= '0;
            end
        end else if (i_ce && serve) begin
            seen_r[pick] <= ~seen_r[pick];
            ack_r[pick] <= ~ack_r[pick];
            last_r <= pick;
            if (!op_wr[pick]) begin
                ack_data_r[pick] <= mem[idx];
            end
        end
    end

    // Storage write, strobed byte lanes only
    always_ff @(posedge i_clk) begin
        if (i_ce && serve && op_wr[pick]) begin
            for (int b = 0; b < STRB_W; b++) begin
                if (op_strb[pick][b]) begin
                    mem[idx][b*8 +: 8] <= op_data[pick][b*8 +: 8];
                end
            end
        end
    end

    // Calibration pin synchronisers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
        end else if (i_ce) begin
            scl_s1 <= i_cal_scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= i_cal_sda;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    assign cal_start = scl_s2 && scl_d && sda_d && !sda_s2;
    assign cal_rise = scl_s2 && !scl_d;
    assign cal_fall = !scl_s2 && scl_d;

    // Calibration frames: header {read, addr[6:0]} then a data byte
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cal_cnt_r <= '0;
            cal_sh_r <= '0;
            cal_tx_r <= 8'hFF;
            cal_rd_r <= 1'b0;
            o_cal_sda_oen <= 1'b1;
            for (int k = 0; k < CAL_REGS; k++) begin
                cfg_r[k] <= CFG_RESET;
            end
        end else if (i_ce) begin
            if (cal_start) begin
                cal_cnt_r <= '0;
                cal_rd_r <= 1'b0;
                o_cal_sda_oen <= 1'b1;
            end else if (cal_rise && cal_cnt_r < CAL_FRAME_BITS) begin
                cal_sh_r <= {cal_sh_r[13:0], sda_s2};
                cal_cnt_r <= cal_cnt_r + 5'h01;
                if (cal_cnt_r == CAL_HDR_BITS - 5'h01) begin
                    cal_rd_r <= cal_sh_r[6];
                    cal_tx_r <= (cal_sh_r[5:1] == 5'h00) ? cfg_r[{cal_sh_r[0], sda_s2}]
                        : 8'hFF;
                end
                if (cal_cnt_r == CAL_FRAME_BITS - 5'h01 && !cal_sh_r[14]
                    && cal_sh_r[13:9] == 5'h00) begin
                    cfg_r[cal_sh_r[8:7]] <= {cal_sh_r[6:0], sda_s2};
                end
            end else if (cal_fall) begin
                if (cal_rd_r && cal_cnt_r >= CAL_HDR_BITS && cal_cnt_r < CAL_FRAME_BITS) begin
                    o_cal_sda_oen <= cal_tx_r[7];
                    cal_tx_r <= {cal_tx_r[6:0], 1'b1};
                end else begin
                    o_cal_sda_oen <= 1'b1;
                end
            end
        end
    end

    // Checks on core sequencing
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_no_serve_early: assert property (!o_init_done |-> ##1 $stable(ack_r))
        else $error("memory served before init done");
    a_init_length: assert property ((ist_r == S_WAIT && i_ce && i_config_sequencer_go
        && !i_config_sequencer_clear) |=> !o_init_done ##20 (o_init_done || !i_ce
        || $past(i_config_sequencer_clear) || $past(!i_ce)))
        else $error("init done not on time");
    a_clear_stops: assert property ((i_ce && i_config_sequencer_clear) |=> !o_init_done)
        else $error("clear did not stop the sequencer");
endmodule
`default_nettype wire

// ---- verification/axi_master_model.sv ----
`default_nettype none
// ==========================================================
// Fabric-side master for one port
module axi_master_model
    import ddr_ctrl_pkg::*;
(
    // Answers from the controller
    input wire logic i_aclk, i_ready, i_wready, i_bvalid, i_rvalid, i_rlast,
    input wire logic [ID_W-1:0] i_bid, i_rid,
    input wire logic [1:0] i_bresp, i_rresp,
    input wire logic [DATA_W-1:0] i_rdata,
    // Requests to the controller
    output logic o_valid, o_dir, o_wvalid, o_wlast, o_bready, o_rready,
    output logic [ADDR_W-1:0] o_addr,
    output logic [ID_W-1:0] o_tag, o_wid,
    output logic [LEN_W-1:0] o_beats,
    output logic [1:0] o_kind,
    output logic [DATA_W-1:0] o_wdata,
    output logic [STRB_W-1:0] o_wstrb
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle master
    initial begin
        {o_valid, o_dir, o_wvalid, o_wlast, o_bready, o_rready} = '0;
        {o_addr, o_tag, o_wid, o_beats, o_kind, o_wdata, o_wstrb} = '0;
    end
    // Request held until taken, then address scrambled
    task automatic req(input logic d, input logic [ADDR_W-1:0] a, input logic [ID_W-1:0] t,
        input logic [LEN_W-1:0] n, input logic [1:0] k);
        @(posedge i_aclk) #1;
        {o_valid, o_dir, o_addr, o_tag, o_beats, o_kind} = {1'b1, d, a, t, n, k};
        do @(posedge i_aclk); while (i_ready !== 1'b1);
        #1 {o_valid, o_addr} = {1'b0, ~a};
    endtask
    // Incrementing write burst and its response
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [ID_W-1:0] t,
        input logic [LEN_W-1:0] n, input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s,
        output logic [ID_W-1:0] id, output logic [1:0] rs);
        req(1'b1, a, t, n, BURST_INCR);
        for (int i = 0; i <= n; i++) begin
            @(posedge i_aclk) #1;
            {o_wvalid, o_wdata, o_wstrb, o_wid, o_wlast} = {1'b1, d + i, s, t, i == n};
            do @(posedge i_aclk); while (i_wready !== 1'b1);
            #1 {o_wvalid, o_wdata} = {1'b0, ~o_wdata};
        end
        @(posedge i_aclk) #1 o_bready = 1'b1;
        do @(posedge i_aclk); while (i_bvalid !== 1'b1);
        {id, rs} = {i_bid, i_bresp};
        #1 o_bready = 1'b0;
    endtask
    // Two-beat read burst
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [ID_W-1:0] t,
        input logic [1:0] k, output logic [1:0][DATA_W-1:0] d, output logic [1:0] l,
        output logic [ID_W-1:0] id, output logic [1:0] rs);
        req(1'b0, a, t, 8'h01, k);
        for (int i = 0; i < 2; i++) begin
            @(posedge i_aclk) #1 o_rready = 1'b1;
            do @(posedge i_aclk); while (i_rvalid !== 1'b1);
            {d[i], l[i], id, rs} = {i_rdata, i_rlast, i_rid, i_rresp};
            #1 o_rready = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- verification/ddr_memory_controller_axi_ports_tb.sv ----
`default_nettype none
module ddr_memory_controller_axi_ports_tb
    import ddr_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, nrst, go, clear, init_done, oen;
    logic [1:0] aclk;
    int checks = 0, fail_count = 0, cycles = 0;
    wire logic [1:0] av, ar, dir, wv, wr, wl, bv, br, rv, rr, rl;
    wire logic [1:0][ADDR_W-1:0] ad;
    wire logic [1:0][ID_W-1:0] tg, wi, bi, ri;
    wire logic [1:0][LEN_W-1:0] ln;
    wire logic [1:0][1:0] kd, bs, rs;
    wire logic [1:0][DATA_W-1:0] wd, rd;
    wire logic [1:0][STRB_W-1:0] ws;
    // ==========================================================
    // Controller and the two fabric masters
    ddr_ctrl dut (.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_aclk(aclk),
        .i_config_sequencer_go(go), .i_config_sequencer_clear(clear), .o_init_done(init_done),
        .i_cal_scl(1'b1), .i_cal_sda(1'b1), .o_cal_sda_oen(oen), .i_shared_request_valid(av),
        .o_shared_request_ready(ar), .i_request_direction_bit(dir), .i_shared_request_address(ad),
        .i_shared_request_tag(tg), .i_shared_burst_beats(ln), .i_shared_beat_size({2{3'h4}}),
        .i_shared_burst_kind(kd), .i_shared_atomic_kind(4'h0),
        .i_wvalid(wv), .o_wready(wr),
        .i_wdata(wd), .i_wstrb(ws), .i_wid(wi), .i_wlast(wl), .o_bvalid(bv), .i_bready(br),
        .o_bid(bi), .o_bresp(bs), .o_rvalid(rv), .i_rready(rr), .o_rdata(rd), .o_rid(ri),
        .o_rlast(rl), .o_rresp(rs));
    for (genvar g = 0; g < 2; g++) begin : g_m
        axi_master_model m (.i_aclk(aclk[g]), .i_ready(ar[g]), .i_wready(wr[g]), .i_bvalid(bv[g]),
            .i_rvalid(rv[g]), .i_rlast(rl[g]), .i_bid(bi[g]), .i_rid(ri[g]), .i_bresp(bs[g]),
            .i_rresp(rs[g]), .i_rdata(rd[g]), .o_valid(av[g]), .o_dir(dir[g]), .o_wvalid(wv[g]),
            .o_wlast(wl[g]), .o_bready(br[g]), .o_rready(rr[g]), .o_addr(ad[g]), .o_tag(tg[g]),
            .o_wid(wi[g]), .o_beats(ln[g]), .o_kind(kd[g]), .o_wdata(wd[g]), .o_wstrb(ws[g]));
    end
    // ==========================================================
    // Clocks and hang guard
    always #2.5 clk = ~clk;
    always #3 aclk = ~aclk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    // Compare and count
    task automatic check(input string n, input logic [DATA_W-1:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic start_up();
        @(posedge clk) #1 clear = 1'b1;
        @(posedge clk) #1 clear = 1'b0;
        check("init_low", init_done, 1'b0);
        check("ready_early", ar, 2'h0);
        check("cal_idle", oen, 1'b1);
        @(posedge clk) #1 go = 1'b1;
        @(posedge clk) #1 go = 1'b0;
        repeat (INIT_CYCLES + 4) @(posedge clk);
        check("init_done", init_done, 1'b1);
        repeat (8) @(posedge aclk[0]);
        check("ready", ar, 2'h3);
    endtask
    task automatic strobe_merge();
        logic [ID_W-1:0] id;
        logic [1:0] st, l;
        logic [1:0][DATA_W-1:0] d;
        logic [DATA_W-1:0] e;
        e = {{2{32'h1111_2222}}, {2{32'h3333_4444}}};
        g_m[0].m.wr(32'h0000_0010, 8'h5A, 8'h00, {4{32'h1111_2222}}, 16'hFFFF, id, st);
        check("bid", id, 8'h5A);
        check("bresp", st, RESP_OKAY);
        g_m[0].m.wr(32'h0000_0010, 8'hA5, 8'h00, {4{32'h3333_4444}}, 16'h00FF, id, st);
        g_m[1].m.rd(32'h0000_0010, 8'h3C, BURST_FIXED, d, l, id, st);
        check("merged", d[0], e);
        check("fixed", d[1], e);
        check("rid", id, 8'h3C);
        check("rlast", l, 2'h2);
        check("rresp", st, RESP_OKAY);
    endtask
    task automatic burst_kinds();
        logic [ID_W-1:0] id;
        logic [1:0] st, l;
        logic [1:0][DATA_W-1:0] d;
        g_m[1].m.wr(32'h0000_0100, 8'h07, 8'h01, 128'h0000_0100, 16'hFFFF, id, st);
        check("bid2", id, 8'h07);
        g_m[0].m.rd(32'h0000_0100, 8'h11, BURST_INCR, d, l, id, st);
        check("incr0", d[0], 128'h0000_0100);
        check("incr1", d[1], 128'h0000_0101);
        g_m[0].m.rd(32'h0000_0110, 8'h12, BURST_WRAP, d, l, id, st);
        check("wrap0", d[0], 128'h0000_0101);
        check("wrap1", d[1], 128'h0000_0100);
        check("wrap_last", l, 2'h2);
        check("rid2", id, 8'h12);
    endtask
    task automatic reset_again();
        @(posedge clk) #1 nrst = 1'b0;
        repeat (2) @(posedge clk) #1;
        nrst = 1'b1;
        repeat (8) @(posedge aclk[0]);
        check("init_again", init_done, 1'b0);
        check("ready_again", ar, 2'h0);
        start_up();
    endtask
    // Main sequence
    initial begin
        {clk, nrst, go, clear} = '0;
        aclk = 2'b01;
        repeat (2) @(posedge clk) #1;
        nrst = 1'b1;
        start_up();
        strobe_merge();
        burst_kinds();
        reset_again();
        give_verdict();
    end
endmodule
`default_nettype wire
